// *** tcdp_pkg.sv ***
// Purpose: Shared constants and types for the timer capture, DMA and
//          prescaler block.
// Assumes: 32-bit plain register port, 100 MHz system clock.
// Notes:   Offsets are word byte addresses on the plain register port.
package tcdp_pkg;

  // Register byte offsets
  localparam logic [7:0] TCDP_OFF_CAPB = 8'h00; // Capture value b (RO)
  localparam logic [7:0] TCDP_OFF_DMAEN = 8'h04; // DMA request enables
  localparam logic [7:0] TCDP_OFF_RUN = 8'h08; // Prescaler run control
  localparam logic [7:0] TCDP_OFF_CLKCFG = 8'h0c; // Clock selection
  localparam logic [7:0] TCDP_OFF_MASK = 8'h10; // Event mask register
  localparam logic [7:0] TCDP_OFF_FLAG = 8'h14; // Event flags, read clears
  localparam logic [7:0] TCDP_OFF_IRQMSK = 8'h18; // Interrupt line mask

  // Field positions
  localparam int TCDP_BIT_DMA_CAPA = 0; // Capture a enable
  localparam int TCDP_BIT_DMA_CAPB = 1; // Capture b enable
  localparam int TCDP_BIT_DMA_MATCH = 2; // Compare match enable
  localparam int TCDP_BIT_RUN = 0; // Prescaler run
  localparam int TCDP_BIT_DIRECT = 1; // Direct tick select
  localparam int TCDP_BIT_FPSEL = 3; // Peripheral clock source select
  localparam int TCDP_LSB_PRCK = 0; // Prescaler clock code, 3 bits
  localparam int TCDP_LSB_TSEL = 4; // Divided tick select, 2 bits

  // Reset values and the clock code for divide by 32
  localparam logic [2:0] TCDP_RST_DMAEN = 3'h0;
  localparam logic [2:0] TCDP_RST_EVT = 3'h0;
  localparam logic [3:0] TCDP_RST_PRESC = 4'h0;
  localparam logic [2:0] TCDP_PRCK_MAX = 3'h5; // Code for divide by 32

  // Event vector: bit0 capture a, bit1 capture b, bit2 match
  typedef logic [2:0] tcdp_evt_t;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } tcdp_bus_t;

  // Whole block state
  typedef struct packed {
    logic [15:0] capb;
    tcdp_evt_t dmaen;
    logic run;
    logic direct;
    logic fpsel;
    logic [2:0] prck;
    logic [1:0] tsel;
    tcdp_evt_t mask;
    tcdp_evt_t flag;
    tcdp_evt_t irqmsk;
    logic [4:0] base_div;
    logic [3:0] presc;
    logic presc_ext; // Extra divide stage, read only by the /32 tap
    logic tick;
    tcdp_evt_t dreq;
    logic irq;
    logic [31:0] rdata;
  } tcdp_state_t;

endpackage

// *** tcdp_top.sv ***
// Purpose: Capture register b, DMA request enables and 4-bit prescaler
//          of one 16-bit timer channel.
// Assumes: Events and counter value come from channel logic on sys_clk_i;
//          peripheral clock is modelled as enables from the clock unit.
// Notes:   All state is one packed struct registered in one process.
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/1ns
`default_nettype none

// No per-channel options exist, so every instance acts the same
module tcdp_top (
  input wire logic sys_clk_i, // 100 MHz system clock
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic ce_i, // Clock enable, freezes all state
  input wire logic [7:0] addr_i, // Register byte address
  input wire logic [31:0] wdata_i, // Write data
  input wire logic wr_i, // Write strobe
  input wire logic rd_i, // Read strobe
  output logic [31:0] rdata_o, // Read data, cycle after strobe
  input wire logic gear_en_i, // One-cycle enable at the geared clock
  input wire logic osc_en_i, // One-cycle enable at oscillator clock
  input wire logic [15:0] up_counter_i, // Up-counter value
  input wire logic cap_a_i, // Capture into register a this cycle
  input wire logic cap_b_i, // Capture into register b this cycle
  input wire logic match_i, // Compare match this cycle
  output logic count_tick_o, // Source tick for the up-counter
  output logic [2:0] dma_req_o, // DMA requests: cap a, cap b, match
  output logic irq_o // Level interrupt
);

  tcdp_pkg::tcdp_state_t state_reg; // Registered state
  tcdp_pkg::tcdp_state_t state_next; // Next state
  tcdp_pkg::tcdp_bus_t bus; // Bundled request
  tcdp_pkg::tcdp_evt_t evt; // Events this cycle
  logic periph_en; // Peripheral clock enable
  logic base_en; // Base tick enable
  logic [4:0] div_mask; // Base divider terminal mask
  logic div_wrap; // Base divider terminal
  logic tap_hit; // Selected prescaler tap reached this base tick

  assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
  assign evt = {match_i, cap_b_i, cap_a_i};

  // Peripheral clock picks gear or undivided oscillator
  assign periph_en = state_reg.fpsel ? osc_en_i : gear_en_i;

  // Base tick divider: terminal when masked low bits are all ones
  always_comb begin
    unique case (state_reg.prck)
      3'h0: div_mask = 5'h00;
      3'h1: div_mask = 5'h01;
      3'h2: div_mask = 5'h03;
      3'h3: div_mask = 5'h07;
      3'h4: div_mask = 5'h0f;
      default: div_mask = 5'h1f; // Codes above five behave as /32
    endcase
  end
  assign div_wrap = (state_reg.base_div & div_mask) == div_mask;
  assign base_en = periph_en && div_wrap;

  // Prescaler tap: direct tick, or /2, /8, /32 of base tick. The 4-bit
  // stage alone tops out at /16, so its wrap flips one extra bit that
  // only the /32 tap reads; select codes 2 and 3 both give /32.
  always_comb begin
    tap_hit = 1'b1; // Direct tick: every base tick counts
    if (!state_reg.direct) begin
      unique case (state_reg.tsel)
        2'h0: tap_hit = state_reg.presc[0]; // Every second base tick
        2'h1: tap_hit = &state_reg.presc[2:0]; // Every eighth
        default: tap_hit = &state_reg.presc && state_reg.presc_ext; // /32
      endcase
    end
  end

  // Next-state logic for the whole block
  always_comb begin
    state_next = state_reg;
    state_next.dreq = 3'h0;
    state_next.tick = 1'b0;
    // Capture b tracks the counter on each capture
    if (cap_b_i) begin
      state_next.capb = up_counter_i;
    end
    // Masked events still flag; set wins over read clear
    state_next.flag = (bus.rd && bus.addr == tcdp_pkg::TCDP_OFF_FLAG)
                      ? evt : (state_reg.flag | evt);
    // Pulse requests only for enabled and unmasked events; the request
    // rides the same edge that records the event, so it is one cycle
    state_next.dreq = evt & state_reg.dmaen
                      & state_reg.mask;
    // Prescaler: halted and cleared while run is low
    if (!state_reg.run) begin
      state_next.presc = tcdp_pkg::TCDP_RST_PRESC;
      state_next.presc_ext = 1'b0;
      state_next.base_div = 5'h00;
    end else if (base_en) begin
      // Base tick: restart the input divider and step the prescaler
      state_next.base_div = 5'h00;
      state_next.presc = state_reg.presc + 4'h1;
      // Extra stage flips on each wrap of the 4-bit count
      state_next.presc_ext = state_reg.presc_ext ^ (&state_reg.presc);
      state_next.tick = tap_hit;
    end else if (periph_en) begin
      // Peripheral clock edge short of the base tick: keep dividing
      state_next.base_div = state_reg.base_div + 5'h01;
    end
    // Register writes; unmapped addresses are ignored
    if (bus.wr) begin
      unique case (bus.addr)
        tcdp_pkg::TCDP_OFF_DMAEN: state_next.dmaen = bus.wdata[2:0];
        tcdp_pkg::TCDP_OFF_RUN: begin
          state_next.run = bus.wdata[tcdp_pkg::TCDP_BIT_RUN];
          state_next.direct = bus.wdata[tcdp_pkg::TCDP_BIT_DIRECT];
          state_next.tsel = bus.wdata[tcdp_pkg::TCDP_LSB_TSEL +: 2];
        end
        tcdp_pkg::TCDP_OFF_CLKCFG: begin
          state_next.prck = bus.wdata[tcdp_pkg::TCDP_LSB_PRCK +: 3];
          state_next.fpsel = bus.wdata[tcdp_pkg::TCDP_BIT_FPSEL];
        end
        tcdp_pkg::TCDP_OFF_MASK: state_next.mask = bus.wdata[2:0];
        tcdp_pkg::TCDP_OFF_IRQMSK: state_next.irqmsk = bus.wdata[2:0];
        default: ; // Read-only or unmapped: no effect
      endcase
    end
    // Read data, valid the cycle after the strobe only
    state_next.rdata = 32'h0;
    if (bus.rd) begin
      unique case (bus.addr)
        tcdp_pkg::TCDP_OFF_CAPB:
          state_next.rdata = {16'h0, state_reg.capb};
        tcdp_pkg::TCDP_OFF_DMAEN:
          state_next.rdata = {29'h0, state_reg.dmaen};
        tcdp_pkg::TCDP_OFF_RUN:
          state_next.rdata = {26'h0, state_reg.tsel, 2'h0,
                              state_reg.direct, state_reg.run};
        tcdp_pkg::TCDP_OFF_CLKCFG:
          state_next.rdata = {28'h0, state_reg.fpsel, state_reg.prck};
        tcdp_pkg::TCDP_OFF_MASK: state_next.rdata = {29'h0, state_reg.mask};
        tcdp_pkg::TCDP_OFF_FLAG: state_next.rdata = {29'h0, state_reg.flag};
        tcdp_pkg::TCDP_OFF_IRQMSK:
          state_next.rdata = {29'h0, state_reg.irqmsk};
        default: state_next.rdata = 32'h0; // Unmapped reads zero
      endcase
    end
    state_next.irq = |(state_next.flag & state_next.irqmsk);
  end

  // State register; capture value is left alone at reset
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_reg.dmaen <= tcdp_pkg::TCDP_RST_DMAEN;
      state_reg.run <= 1'b0;
      state_reg.direct <= 1'b0;
      state_reg.fpsel <= 1'b0;
      state_reg.prck <= 3'h0;
      state_reg.tsel <= 2'h0;
      state_reg.mask <= tcdp_pkg::TCDP_RST_EVT;
      state_reg.flag <= tcdp_pkg::TCDP_RST_EVT;
      state_reg.irqmsk <= tcdp_pkg::TCDP_RST_EVT;
      state_reg.base_div <= 5'h00;
      state_reg.presc <= tcdp_pkg::TCDP_RST_PRESC;
      state_reg.presc_ext <= 1'b0;
      state_reg.tick <= 1'b0;
      state_reg.dreq <= 3'h0;
      state_reg.irq <= 1'b0;
      state_reg.rdata <= 32'h0;
      // Capture b is left out on purpose: its value stays undefined
      // until the first capture, and its upper half is a constant zero
    end else if (ce_i) begin
      // Clock enable low freezes every field, capture b included
      state_reg <= state_next;
    end
  end

  assign rdata_o = state_reg.rdata;
  assign count_tick_o = state_reg.tick;
  assign dma_req_o = state_reg.dreq;
  assign irq_o = state_reg.irq;

  // Checks
  // Enabled, unmasked match asks the DMA controller
  property p_dma_match;
    @(posedge sys_clk_i) disable iff (rst_i)
    (ce_i && match_i && state_reg.dmaen[2] && state_reg.mask[2])
      |=> dma_req_o[2];
  endproperty
  a_dma_match: assert property (p_dma_match)
    else $error("match dma lost");

  // Enabled, unmasked capture b asks the DMA controller
  property p_dma_capb;
    @(posedge sys_clk_i) disable iff (rst_i)
    (ce_i && cap_b_i && state_reg.dmaen[1] && state_reg.mask[1])
      |=> dma_req_o[1];
  endproperty
  a_dma_capb: assert property (p_dma_capb)
    else $error("capb dma lost");

  // Enabled, unmasked capture a asks the DMA controller
  property p_dma_capa;
    @(posedge sys_clk_i) disable iff (rst_i)
    (ce_i && cap_a_i && state_reg.dmaen[0] && state_reg.mask[0])
      |=> dma_req_o[0];
  endproperty
  a_dma_capa: assert property (p_dma_capa)
    else $error("capa dma lost");

  // Mask bit low blocks the match request even when enabled
  property p_masked;
    @(posedge sys_clk_i) disable iff (rst_i)
    (ce_i && !state_reg.mask[2]) |=> !dma_req_o[2];
  endproperty
  a_masked: assert property (p_masked)
    else $error("masked dma issued");

  // Match leaves its status bit set whatever the masks say
  property p_flag;
    @(posedge sys_clk_i) disable iff (rst_i)
    (ce_i && match_i) |=> state_reg.flag[2];
  endproperty
  a_flag: assert property (p_flag)
    else $error("flag not set");

  // Capture b holds the counter value seen at the capture
  property p_capb;
    @(posedge sys_clk_i) disable iff (rst_i)
    (ce_i && cap_b_i) |=> state_reg.capb == $past(up_counter_i);
  endproperty
  a_capb: assert property (p_capb)
    else $error("capture b wrong");

  // Run low clears the prescaler count
  property p_stop;
    @(posedge sys_clk_i) disable iff (rst_i)
    (ce_i && !state_reg.run) |=> state_reg.presc == 4'h0;
  endproperty
  a_stop: assert property (p_stop)
    else $error("prescaler not cleared");

  // Enable register reads zero above bit 2
  property p_dmaen_rd;
    @(posedge sys_clk_i) disable iff (rst_i)
    (ce_i && rd_i && addr_i == tcdp_pkg::TCDP_OFF_DMAEN)
      |=> rdata_o[31:3] == 29'h0;
  endproperty
  a_dmaen_rd: assert property (p_dmaen_rd)
    else $error("upper bits set");

  // A masked line stays low while the flag still records the match
  property p_noirq;
    @(posedge sys_clk_i) disable iff (rst_i)
    (ce_i && !wr_i && match_i && state_reg.irqmsk == 3'h0)
      |=> state_reg.flag[2] && !irq_o;
  endproperty
  a_noirq: assert property (p_noirq)
    else $error("irq unmasked");

  // Capture b upper half reads zero from reset on
  property p_capb_hi;
    @(posedge sys_clk_i) disable iff (rst_i)
    (ce_i && rd_i && addr_i == tcdp_pkg::TCDP_OFF_CAPB)
      |=> rdata_o[31:16] == 16'h0;
  endproperty
  a_capb_hi: assert property (p_capb_hi)
    else $error("capture b upper half set");

  // Reset leaves every DMA enable cleared and no request out
  property p_dmaen_rst;
    @(posedge sys_clk_i)
    rst_i |=> state_reg.dmaen == 3'h0 && dma_req_o == 3'h0;
  endproperty
  a_dmaen_rst: assert property (p_dmaen_rst)
    else $error("enables not cleared by reset");

  // A request only ever follows an event of the cycle before
  property p_no_evt;
    @(posedge sys_clk_i) disable iff (rst_i)
    (ce_i && evt == 3'h0) |=> dma_req_o == 3'h0;
  endproperty
  a_no_evt: assert property (p_no_evt)
    else $error("request without event");

  // A stopped prescaler sends no tick to the up-counter
  property p_tick_stop;
    @(posedge sys_clk_i) disable iff (rst_i)
    (ce_i && !state_reg.run) |=> !count_tick_o;
  endproperty
  a_tick_stop: assert property (p_tick_stop)
    else $error("tick while stopped");

  // Direct select passes every base tick straight through
  property p_direct;
    @(posedge sys_clk_i) disable iff (rst_i)
    (ce_i && state_reg.run && state_reg.direct && base_en) |=> count_tick_o;
  endproperty
  a_direct: assert property (p_direct)
    else $error("direct tick lost");

  // Geared source selected: no tick without a geared clock edge
  property p_gear;
    @(posedge sys_clk_i) disable iff (rst_i)
    (ce_i && !state_reg.fpsel && !gear_en_i) |=> !count_tick_o;
  endproperty
  a_gear: assert property (p_gear)
    else $error("tick off the geared clock");

  // Each base tick steps the 4-bit prescaler by one
  property p_presc_step;
    @(posedge sys_clk_i) disable iff (rst_i)
    (ce_i && state_reg.run && base_en)
      |=> state_reg.presc == $past(state_reg.presc) + 4'h1;
  endproperty
  a_presc_step: assert property (p_presc_step)
    else $error("prescaler did not step");

  c_match: cover property (@(posedge sys_clk_i) dma_req_o[2]);
  c_capb: cover property (@(posedge sys_clk_i) dma_req_o[1]);
  c_capa: cover property (@(posedge sys_clk_i) dma_req_o[0]);
  c_tick: cover property (@(posedge sys_clk_i) count_tick_o);
  c_irq: cover property (@(posedge sys_clk_i) irq_o);

endmodule

`default_nettype wire

// *** tcdp_far_model.sv ***
// Purpose: Far side of the block: clock unit enables and DMA controller.
// Assumes: Oscillator enable every cycle, geared enable every third cycle.
// Notes:   Counts cycles with each DMA request high, so a stretched
//          request shows up as an extra count.
`timescale 1ns/1ns
`default_nettype none

module tcdp_far_model (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic [2:0] dma_req_i, // Requests from the block
  output logic gear_en_o, // Slow geared clock enable
  output logic osc_en_o, // Fast oscillator clock enable
  output logic [23:0] req_cnt_o // Request counts, 8 bits per source
);
  logic [1:0] gear_div_reg; // Divide by three for the geared clock

  // Enables and request counters
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gear_div_reg <= 2'h0;
      gear_en_o <= 1'b0;
      osc_en_o <= 1'b0;
      req_cnt_o <= 24'h0;
    end else begin
      gear_div_reg <= (gear_div_reg == 2'h2) ? 2'h0 : gear_div_reg + 2'h1;
      gear_en_o <= (gear_div_reg == 2'h2);
      osc_en_o <= 1'b1;
      for (int i = 0; i < 3; i++) begin
        if (dma_req_i[i]) begin
          req_cnt_o[i*8 +: 8] <= req_cnt_o[i*8 +: 8] + 8'h01;
        end
      end
    end
  end
endmodule

`default_nettype wire

// *** tb_tcdp_top.sv ***
// Purpose: Self-checking bench for the capture, DMA and prescaler block.
// Assumes: Register port with read data one cycle after the strobe.
// Notes:   Tick periods are measured between two successive ticks.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin \
  miscompares++; $display("CHECK FAILED %s exp %h got %h", nm, ex, got); \
  end end

module tb_tcdp_top;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic ce = 1'b1; // Clock enable, dropped once to prove the freeze
  logic [2:0] ev = 3'h0; // Bit0 capture a, bit1 capture b, bit2 match
  logic [15:0] ucnt = 16'h0;
  logic [31:0] rdata;
  logic tick, irq, gear_en, osc_en;
  logic [2:0] dreq;
  logic [23:0] cnt;
  logic [23:0] exp_cnt = 24'h0;
  int miscompares = 0;
  int checks = 0;
  int cyc = 0;
  int p;

  always #5 sys_clk_i = ~sys_clk_i;

  tcdp_top i_tcdp_top (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr_s), .rd_i(rd_s),
    .rdata_o(rdata), .gear_en_i(gear_en), .osc_en_i(osc_en),
    .up_counter_i(ucnt), .cap_a_i(ev[0]), .cap_b_i(ev[1]),
    .match_i(ev[2]), .count_tick_o(tick), .dma_req_o(dreq), .irq_o(irq));

  tcdp_far_model i_tcdp_far_model (.clk_i(sys_clk_i), .rst_i(rst_i),
    .dma_req_i(dreq), .gear_en_o(gear_en), .osc_en_o(osc_en),
    .req_cnt_o(cnt));

  // Ends the run with the verdict
  task automatic summarize();
    if (miscompares == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Cuts a hang short
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      summarize();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    addr <= a; wdata <= d; wr_s <= 1'b1;
    @(posedge sys_clk_i);
    wr_s <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] ex, m,
                    input string nm);
    @(posedge sys_clk_i);
    addr <= a; rd_s <= 1'b1;
    @(posedge sys_clk_i);
    rd_s <= 1'b0;
    @(negedge sys_clk_i);
    `CHK(nm, ex & m, rdata & m)
  endtask

  // One-cycle event pulse, then time for the request to settle
  task automatic fire(input logic [2:0] v);
    @(posedge sys_clk_i);
    ev <= v;
    @(posedge sys_clk_i);
    ev <= 3'h0;
    repeat (3) @(posedge sys_clk_i);
  endtask

  // Cycles between two successive ticks, bounded
  task automatic period(output int q);
    int n;
    n = 0;
    do begin @(posedge sys_clk_i); n++; end while (tick !== 1'b1 && n < 3000);
    q = 0;
    do begin @(posedge sys_clk_i); q++; end while (tick !== 1'b1 && q < 3000);
  endtask

  initial begin
    repeat (6) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    rd(tcdp_pkg::TCDP_OFF_DMAEN, 32'h0, '1, "dmaen reset");
    rd(tcdp_pkg::TCDP_OFF_CAPB, 32'h0, 32'hffff0000, "capb high");
    wr(tcdp_pkg::TCDP_OFF_DMAEN, 32'hffffffff);
    rd(tcdp_pkg::TCDP_OFF_DMAEN, 32'h7, '1, "dmaen bits");
    rd(8'h1c, 32'h0, '1, "unmapped");
    // Capture b plus interrupt line on its flag
    wr(tcdp_pkg::TCDP_OFF_IRQMSK, 32'h2);
    ucnt <= 16'ha5c3;
    fire(3'h2);
    `CHK("irq on", 1'b1, irq)
    wr(tcdp_pkg::TCDP_OFF_CAPB, 32'h1234);
    rd(tcdp_pkg::TCDP_OFF_CAPB, 32'ha5c3, '1, "capb value");
    rd(tcdp_pkg::TCDP_OFF_FLAG, 32'h2, '1, "flag capb");
    @(negedge sys_clk_i);
    `CHK("irq off", 1'b0, irq)
    wr(tcdp_pkg::TCDP_OFF_IRQMSK, 32'h0);
    // Each enable alone routes only its own event
    wr(tcdp_pkg::TCDP_OFF_MASK, 32'h7);
    ucnt <= 16'hffff;
    for (int i = 0; i < 3; i++) begin
      wr(tcdp_pkg::TCDP_OFF_DMAEN, 32'h1 << i);
      fire(3'h7);
      exp_cnt[i*8 +: 8] = exp_cnt[i*8 +: 8] + 8'h01;
      `CHK("dma one source", exp_cnt, cnt)
    end
    rd(tcdp_pkg::TCDP_OFF_CAPB, 32'hffff, '1, "capb top");
    // Clear flags left by the unmasked events first
    rd(tcdp_pkg::TCDP_OFF_FLAG, 32'h7, '1, "flag dma");
    // Masked events never request, but still flag
    wr(tcdp_pkg::TCDP_OFF_MASK, 32'h0);
    wr(tcdp_pkg::TCDP_OFF_DMAEN, 32'h7);
    fire(3'h7);
    `CHK("dma masked", exp_cnt, cnt)
    rd(tcdp_pkg::TCDP_OFF_FLAG, 32'h7, '1, "flag masked");
    rd(tcdp_pkg::TCDP_OFF_FLAG, 32'h0, '1, "flag cleared");
    // Clock enable low: the events are not registered at all
    @(posedge sys_clk_i);
    ce <= 1'b0;
    fire(3'h7);
    ce <= 1'b1;
    rd(tcdp_pkg::TCDP_OFF_FLAG, 32'h0, '1, "flag frozen");
    // Prescaler: source, input divide and tap
    for (int i = 0; i < 8; i++) begin
      wr(tcdp_pkg::TCDP_OFF_RUN, 32'h0);
      wr(tcdp_pkg::TCDP_OFF_CLKCFG, {28'h0, i < 7, 3'(i % 6)});
      wr(tcdp_pkg::TCDP_OFF_RUN, {26'h0, 2'(i % 4), 2'h0, i == 6, 1'b1});
      period(p);
      `CHK("tick period", ((i < 7) ? 1 : 3) * (1 << (i % 6)) * ((i == 6) ? 1 :
        (i % 4 == 0) ? 2 : (i % 4 == 1) ? 8 : 32), p)
    end
    // Stopping clears and halts the count
    wr(tcdp_pkg::TCDP_OFF_RUN, 32'h0);
    repeat (3) @(posedge sys_clk_i);
    p = 0;
    repeat (64) begin @(posedge sys_clk_i); p += (tick === 1'b1); end
    `CHK("stopped ticks", 0, p)
    summarize();
  end
endmodule

`default_nettype wire
